// *** spi_port.sv ***
// Function
// - Full-duplex, master or slave, selectable order
// - Seven master rates including CPU clock/2
// - Data write during transfer flags collision
// - MOSI master-to-slave, MISO back, master clocks
// - Master data write starts eight-bit shift
// - Clock stops after byte, done flag set
// - Done flag with enable requests interrupt
// - Deselected slave idles, MISO released, writes accepted
// - Slave sets done after full byte
// - Slave may preload next byte anytime idle
// - Last received byte kept in buffer
// - Unread received byte overwritten by next
// - Master forces MISO to input
// - Slave forces MOSI, SCK, select inputs
// - Select high resets slave bit logic
// - Select low in master with select as input: become slave, flag
// - Polarity and phase choose four modes
// - Order bit one sends LSB first
`timescale 1ns/1ps
module spi_port (
    // Clock and reset
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_N_I,
    // Control
    input  wire logic       CTRL_WRITE_I,
    input  wire logic [7:0] CTRL_DATA_I,
    input  wire logic       DOUBLE_SPEED_I,
    input  wire logic       POWER_GATE_I,
    output logic      [7:0] CONTROL_O,
    // Data and status
    input  wire logic       DATA_WRITE_I,
    input  wire logic [7:0] DATA_I,
    input  wire logic       DATA_READ_I,
    input  wire logic       STATUS_READ_I,
    input  wire logic       IRQ_ACK_I,
    output logic      [7:0] RX_DATA_O,
    output logic            TRANSFER_DONE_FLAG_O,
    output logic            WRITE_COLLISION_O,
    output logic            IRQ_O,
    // User pin directions, one means output
    input  wire logic       DIR_MOSI_I,
    input  wire logic       DIR_MISO_I,
    input  wire logic       DIR_SCK_I,
    input  wire logic       DIR_SS_I,
    // Serial pins
    input  wire logic       SCK_I,
    output logic            SCK_O,
    output logic            SCK_OE_N_O,
    input  wire logic       MOSI_I,
    output logic            MOSI_O,
    output logic            MOSI_OE_N_O,
    input  wire logic       MISO_I,
    output logic            MISO_O,
    output logic            MISO_OE_N_O,
    input  wire logic       SS_N_I
);
    logic [7:0] ctrl_reg;
    logic [3:0] s1_reg, s2_reg, s3_reg, pin_reg;
    logic [7:0] sh_reg, rx_reg;
    logic [2:0] bit_cnt_reg;
    logic [3:0] edge_cnt_reg;
    logic       smp_reg, sck_reg, sck_prev_reg;
    logic       flag_reg, wcol_reg, armed_reg;
    spi_pkg::shift_state_type state_reg;

    logic active, master, order, pol, pha, ss_low, sel, mode_fault;
    logic busy, start, m_edge, s_edge, lead, samp, shft, in_bit;
    logic byte_done, last_edge, collide, load, done_set, flag_clr;

    spi_rate_if rate_if ();

    assign rate_if.run  = busy;
    assign rate_if.rate = ctrl_reg[spi_pkg::CTRL_RATE_LSB +:
                                   spi_pkg::CTRL_RATE_W];
    assign rate_if.dbl  = DOUBLE_SPEED_I;

    spi_sck_gen u_sck_gen (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .rate_if (rate_if)
    );

    function automatic logic [7:0] shift_in(input logic [7:0] d,
                                            input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    assign active = ctrl_reg[spi_pkg::CTRL_ENABLE_BIT] & ~POWER_GATE_I;
    assign master = ctrl_reg[spi_pkg::CTRL_MASTER_BIT];
    assign order  = ctrl_reg[spi_pkg::CTRL_ORDER_BIT];
    assign pol    = ctrl_reg[spi_pkg::CTRL_POL_BIT];
    assign pha    = ctrl_reg[spi_pkg::CTRL_PHA_BIT];
    assign ss_low = ~pin_reg[spi_pkg::PIN_SS];
    assign sel    = active & ~master & ss_low;
    assign busy   = (state_reg == spi_pkg::ST_SHIFT);

    assign mode_fault = active & master & ~DIR_SS_I & ss_low;
    assign start = active & master & DATA_WRITE_I & ~busy & ~mode_fault;

    // slave clock seen only after filtering
    assign s_edge = sel & (pin_reg[spi_pkg::PIN_SCK] != sck_prev_reg);
    assign m_edge = busy & rate_if.tick;
    assign lead   = master ? ~edge_cnt_reg[0]
                           : (pin_reg[spi_pkg::PIN_SCK] != pol);
    assign samp = (m_edge | s_edge) & (lead ^ pha);
    assign shft = (m_edge | s_edge) & ~(lead ^ pha) & (bit_cnt_reg != 3'h0);
    assign in_bit = master ? pin_reg[spi_pkg::PIN_MISO]
                           : pin_reg[spi_pkg::PIN_MOSI];
    assign byte_done = samp & (bit_cnt_reg == spi_pkg::BIT_CNT_LAST);
    assign last_edge = m_edge & (edge_cnt_reg == spi_pkg::EDGE_CNT_LAST);

    assign collide = DATA_WRITE_I & active &
                     (master ? busy : (sel & (bit_cnt_reg != 3'h0)));
    assign load = DATA_WRITE_I & ~collide;

    // Input pins: a change counts once stages two and three agree
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s1_reg  <= spi_pkg::PIN_SYNC_RESET;
            s2_reg  <= spi_pkg::PIN_SYNC_RESET;
            s3_reg  <= spi_pkg::PIN_SYNC_RESET;
            pin_reg <= spi_pkg::PIN_SYNC_RESET;
        end else begin
            s1_reg  <= {SS_N_I, SCK_I, MOSI_I, MISO_I};
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= (s2_reg & ~(s2_reg ^ s3_reg))
                     | (pin_reg & (s2_reg ^ s3_reg));
        end
    end

    // Control byte; hardware drop of master wins over a write
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= spi_pkg::CTRL_RESET;
        end else begin
            if (CTRL_WRITE_I) begin
                ctrl_reg <= CTRL_DATA_I;
            end
            if (mode_fault) begin
                ctrl_reg[spi_pkg::CTRL_MASTER_BIT] <= 1'b0;
            end
        end
    end

    // Master clock sequencer
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg    <= spi_pkg::ST_IDLE;
            edge_cnt_reg <= 4'h0;
            sck_reg      <= 1'b0;
        end else if (!active || mode_fault) begin
            state_reg    <= spi_pkg::ST_IDLE;
            edge_cnt_reg <= 4'h0;
            sck_reg      <= pol;
        end else begin
            case (state_reg)
                spi_pkg::ST_IDLE: begin
                    edge_cnt_reg <= 4'h0;
                    sck_reg      <= pol;
                    if (start) begin
                        state_reg <= spi_pkg::ST_SHIFT;
                    end
                end
                spi_pkg::ST_SHIFT: begin
                    if (m_edge) begin
                        edge_cnt_reg <= edge_cnt_reg + 4'h1;
                        sck_reg      <= ~sck_reg;
                    end
                    if (last_edge) begin
                        state_reg <= spi_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= spi_pkg::ST_IDLE;
            endcase
        end
    end

    // Shift register; slave accepts writes while deselected
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sh_reg <= spi_pkg::DATA_RESET;
        end else if (load) begin
            sh_reg <= DATA_I;
        end else if (shft) begin
            sh_reg <= shift_in(sh_reg, smp_reg, order);
        end
    end

    // Bit counter and sampled bit
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bit_cnt_reg  <= 3'h0;
            smp_reg      <= 1'b0;
            sck_prev_reg <= spi_pkg::PIN_SYNC_RESET[spi_pkg::PIN_SCK];
        end else begin
            sck_prev_reg <= pin_reg[spi_pkg::PIN_SCK];
            if (!active || mode_fault || (!master && !ss_low)) begin
                bit_cnt_reg <= 3'h0;
                smp_reg     <= 1'b0;
            end else if (samp) begin
                smp_reg     <= in_bit;
                bit_cnt_reg <= byte_done ? 3'h0 : bit_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rx_reg <= spi_pkg::DATA_RESET;
        end else if (byte_done) begin
            rx_reg <= shift_in(sh_reg, in_bit, order);
        end
    end

    assign done_set = (byte_done & ~master) | last_edge | mode_fault;
    // ack, or status read then data access
    assign flag_clr = IRQ_ACK_I | (armed_reg & (DATA_WRITE_I | DATA_READ_I));

    // Flags: a set in the clearing cycle wins
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flag_reg  <= 1'b0;
            wcol_reg  <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            flag_reg <= done_set | (flag_reg & ~flag_clr);
            wcol_reg <= collide | (wcol_reg & ~flag_clr);
            if (STATUS_READ_I && (flag_reg || wcol_reg)) begin
                armed_reg <= 1'b1;
            end else if (DATA_WRITE_I || DATA_READ_I || IRQ_ACK_I) begin
                armed_reg <= 1'b0;
            end
        end
    end

    assign IRQ_O = flag_reg & ctrl_reg[spi_pkg::CTRL_IRQ_EN_BIT];
    assign TRANSFER_DONE_FLAG_O = flag_reg;
    assign WRITE_COLLISION_O    = wcol_reg;
    assign RX_DATA_O = rx_reg;
    assign CONTROL_O = ctrl_reg;

    // select is never driven; master MISO input
    assign SCK_O       = sck_reg;
    assign SCK_OE_N_O  = ~(active & master & DIR_SCK_I);
    assign MOSI_OE_N_O = ~(active & master & DIR_MOSI_I);
    // deselected slave releases MISO; slave inputs
    assign MISO_OE_N_O = ~(sel & DIR_MISO_I);
    assign MOSI_O      = order ? sh_reg[0] : sh_reg[7];
    assign MISO_O      = order ? sh_reg[0] : sh_reg[7];

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_master_start;
        active && master && DATA_WRITE_I && !busy && !mode_fault;
    endsequence
    sequence s_last_edge;
        busy && rate_if.tick && (edge_cnt_reg == 4'hF);
    endsequence

    a_master_start: assert property (s_master_start |=> busy)
        else $error("master write did not start shifting");
    a_byte_end: assert property (s_last_edge |=> !busy && flag_reg)
        else $error("master byte end did not stop and flag");
    a_write_collide: assert property (
        DATA_WRITE_I && active && master && busy |=> wcol_reg
        && ($stable(sh_reg) || $past(shft)))
        else $error("collision not flagged or data overwritten");
    a_irq_request: assert property (
        flag_reg && ctrl_reg[7] |-> IRQ_O)
        else $error("interrupt not requested");
    a_slave_idle: assert property (
        active && !master && pin_reg[3] |-> MISO_OE_N_O ##1 bit_cnt_reg == 0)
        else $error("deselected slave not idle");
    a_slave_dirs: assert property (
        !master |-> MOSI_OE_N_O && SCK_OE_N_O)
        else $error("slave drives MOSI or SCK");
    a_master_miso: assert property (master |-> MISO_OE_N_O)
        else $error("master drives MISO");
    a_mode_fault: assert property (
        mode_fault |=> !ctrl_reg[4] && flag_reg && !busy)
        else $error("select low did not demote master");
    a_rx_hold: assert property (!byte_done |=> $stable(rx_reg))
        else $error("receive buffer changed without a byte");
    a_sck_idle: assert property (
        active && master && !busy ##1 !busy && $stable(pol)
        |-> SCK_O == pol)
        else $error("idle clock level differs from polarity");
endmodule

// *** spi_pkg.sv ***
package spi_pkg;
    // Control byte layout
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_ENABLE_BIT = 6;
    localparam int CTRL_ORDER_BIT  = 5;
    localparam int CTRL_MASTER_BIT = 4;
    localparam int CTRL_POL_BIT    = 3;
    localparam int CTRL_PHA_BIT    = 2;
    localparam int CTRL_RATE_LSB   = 0;
    localparam int CTRL_RATE_W     = 2;

    // Reset values
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] DATA_RESET     = 8'h00;
    localparam logic [3:0] PIN_SYNC_RESET = 4'hF;

    // Pin bit positions in the synchronised vector
    localparam int PIN_MISO = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_SCK  = 2;
    localparam int PIN_SS   = 3;

    // Byte framing counts
    localparam logic [2:0] BIT_CNT_LAST  = 3'h7;
    localparam logic [3:0] EDGE_CNT_LAST = 4'hF;

    // Serial clock divisors of the CPU clock, halved at double speed
    localparam int SCK_DIV_0 = 4;
    localparam int SCK_DIV_1 = 16;
    localparam int SCK_DIV_2 = 64;
    localparam int SCK_DIV_3 = 128;

    typedef enum logic {ST_IDLE, ST_SHIFT} shift_state_type;
endpackage

// *** spi_rate_if.sv ***
`timescale 1ns/1ps
interface spi_rate_if;
    logic       run;
    logic [1:0] rate;
    logic       dbl;
    logic       tick;

    modport gen  (input run, input rate, input dbl, output tick);
    modport user (output run, output rate, output dbl, input tick);
endinterface

// *** spi_sck_gen.sv ***
`timescale 1ns/1ps
module spi_sck_gen #(
    parameter int CNT_W = 7
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Rate request and half-period tick
    spi_rate_if.gen  rate_if
);
    int              div;
    logic [CNT_W-1:0] half_m1;
    logic [CNT_W-1:0] cnt_reg;

    always_comb begin
        case (rate_if.rate)
            2'h0:    div = spi_pkg::SCK_DIV_0;
            2'h1:    div = spi_pkg::SCK_DIV_1;
            2'h2:    div = spi_pkg::SCK_DIV_2;
            default: div = spi_pkg::SCK_DIV_3;
        endcase
        // Half a period; double speed halves it again
        half_m1 = CNT_W'((div >> (rate_if.dbl ? 2 : 1)) - 1);
    end

    assign rate_if.tick = rate_if.run && (cnt_reg == half_m1);

    // Counter held at zero while idle so the first edge is a half period late
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (!rate_if.run || rate_if.tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

// *** spi_peer.sv ***
`timescale 1ns/1ps
module spi_peer (
    // Clock and frame format
    input  wire logic       clk_i,
    input  wire logic       pol_i,
    input  wire logic       pha_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    // Slave side, facing a master
    input  wire logic       sel_n_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Master side, facing a slave
    output logic            sck_o,
    output logic            mosi_o,
    input  wire logic       miso_i
);
    logic [7:0] rx_reg   = 8'h00;
    logic       idle_bit = 1'b0;
    logic       busy     = 1'b0;
    logic       sck_q    = 1'b0;
    logic       mosi_q   = 1'b0;
    int         shifts   = 0;
    int         samples  = 0;
    int         idx;

    function automatic logic pick(input logic [7:0] b, input int i);
        return lsb_i ? b[i] : b[7 - i];
    endfunction

    always @(posedge clk_i) idle_bit <= !idle_bit;

    // lines: released data lines toggle rather than hold; idle clock holds polarity
    assign idx    = shifts - int'(pha_i);
    assign miso_o = (!sel_n_i && idx >= 0 && idx < 8) ? pick(tx_i, idx)
                                                       : idle_bit;
    assign sck_o  = busy ? sck_q : pol_i;
    assign mosi_o = busy ? mosi_q : idle_bit;

    // deselect clears count, else sample or shift
    always @(sck_i or posedge sel_n_i) begin
        if (sel_n_i) begin
            shifts  = 0;
            samples = 0;
        end else begin
            #1;
            if (!sel_n_i && ((sck_i != pol_i) == !pha_i) && samples < 8) begin
                rx_reg[lsb_i ? samples : 7 - samples] = mosi_i;
                samples++;
            end else if (!sel_n_i) begin
                shifts++;
            end
        end
    end

    // clocking: only master pulses, long half periods
    task automatic xfer(input int half, input int nbits,
                        output logic [7:0] rx);
        rx    = 8'h00;
        busy  = 1'b1;
        sck_q = pol_i;
        for (int i = 0; i < nbits; i++) begin
            if (pha_i)
                sck_q = !pol_i;
            mosi_q = pick(tx_i, i);
            repeat (half) @(negedge clk_i);
            sck_q = pha_i ? pol_i : !pol_i;
            rx[lsb_i ? i : 7 - i] = miso_i;
            repeat (half) @(negedge clk_i);
            if (!pha_i)
                sck_q = pol_i;
        end
        busy = 1'b0;
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] IE = 8'h01 << spi_pkg::CTRL_IRQ_EN_BIT;
    localparam logic [7:0] EN = 8'h01 << spi_pkg::CTRL_ENABLE_BIT;
    localparam logic [7:0] MS = 8'h01 << spi_pkg::CTRL_MASTER_BIT;
    logic       clk, rst_n, cwr, dwr, drd, srd, ack, dbl, pgate;
    logic       d_mosi, d_miso, d_sck, d_ss, ss_n, p_sel_n;
    logic       pol, pha, lsb, done, wcol, irq;
    logic [7:0] cdat, ddat, ptx, prx, control, rxd;
    logic       sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n;
    logic       p_sck, p_mosi, p_miso, sck_w, mosi_w, miso_w;
    int         num_errors  = 0;
    int         checks_done = 0;
    int         n, h;
    int         divs [4] = '{spi_pkg::SCK_DIV_0, spi_pkg::SCK_DIV_1,
                             spi_pkg::SCK_DIV_2, spi_pkg::SCK_DIV_3};

    assign sck_w  = sck_oe_n ? p_sck : sck;
    assign mosi_w = mosi_oe_n ? p_mosi : mosi;
    assign miso_w = miso_oe_n ? p_miso : miso;

    spi_port DUT (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .CTRL_WRITE_I(cwr),
        .CTRL_DATA_I(cdat), .DOUBLE_SPEED_I(dbl), .POWER_GATE_I(pgate),
        .CONTROL_O(control), .DATA_WRITE_I(dwr), .DATA_I(ddat),
        .DATA_READ_I(drd), .STATUS_READ_I(srd), .IRQ_ACK_I(ack),
        .RX_DATA_O(rxd), .TRANSFER_DONE_FLAG_O(done),
        .WRITE_COLLISION_O(wcol), .IRQ_O(irq), .DIR_MOSI_I(d_mosi),
        .DIR_MISO_I(d_miso), .DIR_SCK_I(d_sck), .DIR_SS_I(d_ss),
        .SCK_I(sck_w), .SCK_O(sck), .SCK_OE_N_O(sck_oe_n),
        .MOSI_I(mosi_w), .MOSI_O(mosi), .MOSI_OE_N_O(mosi_oe_n),
        .MISO_I(miso_w), .MISO_O(miso), .MISO_OE_N_O(miso_oe_n),
        .SS_N_I(ss_n)
    );

    spi_peer peer (
        .clk_i(clk), .pol_i(pol), .pha_i(pha), .lsb_i(lsb), .tx_i(ptx),
        .sel_n_i(p_sel_n), .sck_i(sck_w), .mosi_i(mosi_w),
        .miso_o(p_miso), .sck_o(p_sck), .mosi_o(p_mosi), .miso_i(miso_w)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic set_ctrl(input logic [7:0] b);
        cdat = b;
        cwr  = 1'b1;
        pol  = b[spi_pkg::CTRL_POL_BIT];
        pha  = b[spi_pkg::CTRL_PHA_BIT];
        lsb  = b[spi_pkg::CTRL_ORDER_BIT];
        @(negedge clk);
        cwr  = 1'b0;
    endtask

    task automatic wr_data(input logic [7:0] b);
        ddat = b;
        dwr  = 1'b1;
        @(negedge clk);
        dwr  = 1'b0;
    endtask

    // Order is ack, status read, data read
    task automatic pulse(input logic [2:0] v);
        {ack, srd, drd} = v;
        @(negedge clk);
        {ack, srd, drd} = 3'h0;
    endtask

    task automatic wait_done(input int lim);
        n = 0;
        while (done !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end

    // Longest pass is well under this
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        {rst_n, cwr, dwr, drd, srd, ack, dbl, pgate} = 8'h00;
        {d_mosi, d_miso, d_sck, d_ss, ss_n, p_sel_n} = 6'h3F;
        {pol, pha, lsb} = 3'h0;
        {cdat, ddat, ptx} = 24'h000000;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check(control, spi_pkg::CTRL_RESET);
        check(8'({done, irq, sck_oe_n, mosi_oe_n, miso_oe_n}), 8'h07);
        pgate = 1'b1;
        set_ctrl(EN | MS);
        wr_data(8'hA5);
        wait_done(200);
        check(8'({done, sck}), 8'h00);
        pgate = 1'b0;
        // Master: seven rates, four modes, both orders
        for (int i = 0; i < 8; i++) begin
            dbl = i[0];
            h   = divs[i / 2] / (dbl ? 4 : 2);
            ptx = 8'h3C + 8'(i);
            set_ctrl(EN | MS | (i[0] ? IE : 8'h00) |
                     {2'h0, i[2], 1'b0, i[1:0], i[2:1]});
            repeat (2) @(negedge clk);
            p_sel_n = 1'b0;
            wr_data(8'hC3 ^ 8'(i));
            if (i[0]) begin
                @(negedge clk);
                wr_data(8'h55);
            end
            wait_done(2000);
            n = n + (i[0] ? 2 : 0);
            check(8'(n == 16 * h), 8'h01);
            check(8'(irq), 8'(i[0]));
            check(8'(wcol), 8'(i[0]));
            check(peer.rx_reg, 8'hC3 ^ 8'(i));
            check(8'(peer.shifts + peer.samples), 8'h10);
            check(8'(sck), 8'(pol));
            if (h >= 8)
                check(rxd, ptx);
            check(8'({mosi_oe_n, sck_oe_n, miso_oe_n}), 8'h01);
            p_sel_n = 1'b1;
            pulse(3'h2);
            @(negedge clk);
            pulse(3'h1);
            check(8'({done, wcol, irq}), 8'h00);
        end
        dbl = 1'b0;
        set_ctrl(EN | MS);
        d_ss = 1'b0;
        ss_n = 1'b0;
        repeat (8) @(negedge clk);
        check(8'({control[spi_pkg::CTRL_MASTER_BIT], done, mosi_oe_n,
                 sck_oe_n}), 8'h07);
        {d_ss, ss_n} = 2'h3;
        pulse(3'h4);
        check(8'(done), 8'h00);
        // Slave: every mode, both orders, next byte preloaded unread
        for (int i = 0; i < 4; i++) begin
            set_ctrl(EN | {2'h0, i[0], 1'b0, i[1:0], 2'h0});
            ptx = 8'h96 ^ 8'(i * 17);
            wr_data(8'h5A + 8'(i));
            peer.xfer(8, 8, prx);
            check(8'({done, miso_oe_n}), 8'h01);
            ss_n = 1'b0;
            repeat (8) @(negedge clk);
            check(8'({mosi_oe_n, sck_oe_n, miso_oe_n}), 8'h06);
            if (i == 3) begin
                peer.xfer(8, 3, prx);
                ss_n = 1'b1;
                repeat (8) @(negedge clk);
                ss_n = 1'b0;
                repeat (8) @(negedge clk);
            end
            peer.xfer(8, 8, prx);
            wait_done(40);
            check(8'({done, irq}), 8'h02);
            check(rxd, ptx);
            if (i != 3)
                check(prx, 8'h5A + 8'(i));
            ss_n = 1'b1;
            pulse(3'h4);
        end
        end_of_test();
    end
endmodule
